// ==== verilog/adcc_ctrl.sv ====
// Descriptor chain fetch and sequencing controller
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [RULE1] Active status bit is high while descriptors are being processed.
// [RULE2] Software checks idle and clears errors before a new start.
// [RULE3] Software writes first descriptor address into next-descriptor register.
// [RULE4] Software then sets enable, leaving chain-resume clear for fresh start.
// [RULE5] Start fetches descriptor, moves address to current, loads its next field.
// [RULE6] Zero next-address ends the chain; nothing further is fetched.
// [RULE7] Clearing enable suspends without abort; setting it resumes.
// [RULE8] Completion with non-zero next sets end-of-transfer, interrupts if enabled, continues.
// [RULE9] Completion with zero next sets end-of-chain, interrupts if enabled.
// [RULE10] An error stops the current descriptor and does not advance.
// [RULE11] Interrupt enable comes from each descriptor's own control word.
// [RULE12] Next register holds address to fetch; current holds descriptor in work.
// [RULE13] Software appends by patching last next field, then sets chain-resume.
// [RULE14] Idle or chain end with resume set rereads next field, clears resume.
// [RULE15] Completion of a non-last descriptor clears chain-resume and fetches normally.
// [RULE16] While idle, a control write with resume set rereads last descriptor.
// [RULE17] Last descriptor with resume clear returns to idle.
// [RULE18] Active clears on entering idle after chain end, error or null resume.
module adcc_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   // Control register write strobe and fields
   input wire logic ctl_wr,
   input wire logic ctl_enable,
   input wire logic ctl_resume,
   // Next descriptor address register write
   input wire logic nda_wr,
   input wire logic [31:0] nda_wdata,
   // Software clears of status flags
   input wire logic clr_eot,
   input wire logic clr_eoc,
   input wire logic clr_err,
   // Local memory read port
   output adcc_pkg::adcc_rd_s mem_rd,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata,
   // Datapath handshake
   output logic xfer_start,
   input wire logic xfer_done,
   input wire logic xfer_err,
   // Register views
   output logic [31:0] next_desc_addr_reg,
   output logic [31:0] current_desc_addr_reg,
   output logic enable_o,
   output logic resume_o,
   output adcc_pkg::adcc_stat_s accel_status_reg,
   output logic irq
);
   adcc_pkg::adcc_state_e state_ff, nxt_state;
   logic [31:0] nda_ff, nxt_nda;
   logic [31:0] cda_ff, nxt_cda;
   logic en_ff, nxt_en;
   logic res_ff, nxt_res;
   logic ie_ff, nxt_ie;
   logic act_ff, nxt_act;
   logic irq_ff, nxt_irq;
   logic rd_req_ff, nxt_rd_req;
   logic [31:0] rd_addr_ff, nxt_rd_addr;
   logic start_ff, nxt_start;
   logic set_eot, set_eoc, set_err;
   logic eot_q, eoc_q, err_q;

   // Next state and register updates
   always_comb begin
      nxt_state = state_ff;
      nxt_nda = nda_ff;
      nxt_cda = cda_ff;
      nxt_en = en_ff;
      nxt_res = res_ff;
      nxt_ie = ie_ff;
      nxt_act = act_ff;
      nxt_irq = 1'b0;
      nxt_rd_req = 1'b0;
      nxt_rd_addr = rd_addr_ff;
      nxt_start = 1'b0;
      set_eot = 1'b0;
      set_eoc = 1'b0;
      set_err = 1'b0;
      if (ctl_wr) begin
         nxt_en = ctl_enable;
         nxt_res = ctl_resume;
      end
      if (nda_wr && state_ff == adcc_pkg::ADCC_IDLE) begin
         nxt_nda = nda_wdata;
      end
      case (state_ff)
         adcc_pkg::ADCC_IDLE: begin
            // [RULE16] Idle resume check
            if (ctl_wr && ctl_resume) begin
               nxt_state = adcc_pkg::ADCC_RESUME;
               nxt_rd_req = 1'b1;
               nxt_rd_addr = cda_ff + adcc_pkg::NXT_FIELD_OFS;
               nxt_act = 1'b1;
            end else if (ctl_wr && ctl_enable && nda_ff != adcc_pkg::NULL_ADDR) begin
               // [RULE5] Fresh start fetch
               nxt_state = adcc_pkg::ADCC_RD_NXT;
               nxt_cda = nda_ff;
               nxt_rd_req = 1'b1;
               nxt_rd_addr = nda_ff + adcc_pkg::NXT_FIELD_OFS;
               nxt_act = 1'b1;
            end
         end
         adcc_pkg::ADCC_RD_NXT: begin
            if (mem_rvalid) begin
               // [RULE12] Load next address
               nxt_nda = mem_rdata;
               nxt_state = adcc_pkg::ADCC_RD_CTL;
               nxt_rd_req = 1'b1;
               nxt_rd_addr = cda_ff + adcc_pkg::CTL_FIELD_OFS;
            end else begin
               nxt_rd_req = rd_req_ff;
            end
         end
         adcc_pkg::ADCC_RD_CTL: begin
            if (mem_rvalid) begin
               // [RULE11] Per-descriptor interrupt enable
               nxt_ie = mem_rdata[adcc_pkg::IE_BIT];
               nxt_state = adcc_pkg::ADCC_XFER;
            end else begin
               nxt_rd_req = rd_req_ff;
            end
         end
         adcc_pkg::ADCC_XFER: begin
            // [RULE7] Suspend holds here while disabled
            if (en_ff) begin
               nxt_start = 1'b1;
               nxt_state = adcc_pkg::ADCC_DONE;
            end
         end
         adcc_pkg::ADCC_DONE: begin
            if (xfer_err) begin
               // [RULE10] Halt without advancing
               set_err = 1'b1;
               nxt_act = 1'b0;
               nxt_state = adcc_pkg::ADCC_IDLE;
            end else if (xfer_done) begin
               if (nda_ff != adcc_pkg::NULL_ADDR) begin
                  // [RULE8] Interrupt and continue
                  set_eot = 1'b1;
                  nxt_irq = ie_ff;
                  // [RULE15] Drop resume, fetch next
                  nxt_res = 1'b0;
                  nxt_cda = nda_ff;
                  nxt_rd_req = 1'b1;
                  nxt_rd_addr = nda_ff + adcc_pkg::NXT_FIELD_OFS;
                  nxt_state = adcc_pkg::ADCC_RD_NXT;
               end else begin
                  // [RULE9] End of chain flag
                  set_eoc = 1'b1;
                  nxt_irq = ie_ff;
                  if (res_ff) begin
                     // [RULE14] Reread current next field
                     nxt_rd_req = 1'b1;
                     nxt_rd_addr = cda_ff + adcc_pkg::NXT_FIELD_OFS;
                     nxt_state = adcc_pkg::ADCC_RESUME;
                  end else begin
                     // [RULE17] [RULE6] Back to idle
                     nxt_act = 1'b0;
                     nxt_state = adcc_pkg::ADCC_IDLE;
                  end
               end
            end
         end
         adcc_pkg::ADCC_RESUME: begin
            if (mem_rvalid) begin
               // [RULE14] Clear resume, test new address
               nxt_nda = mem_rdata;
               nxt_res = 1'b0;
               if (mem_rdata != adcc_pkg::NULL_ADDR) begin
                  nxt_cda = mem_rdata;
                  nxt_rd_req = 1'b1;
                  nxt_rd_addr = mem_rdata + adcc_pkg::NXT_FIELD_OFS;
                  nxt_state = adcc_pkg::ADCC_RD_NXT;
               end else begin
                  // [RULE18] Null resume goes idle
                  nxt_act = 1'b0;
                  nxt_state = adcc_pkg::ADCC_IDLE;
               end
            end else begin
               nxt_rd_req = rd_req_ff;
            end
         end
         default: begin
            nxt_state = adcc_pkg::ADCC_IDLE;
            nxt_act = 1'b0;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= adcc_pkg::ADCC_IDLE;
         nda_ff <= adcc_pkg::RST_ADDR;
         cda_ff <= adcc_pkg::RST_ADDR;
         en_ff <= 1'b0;
         res_ff <= 1'b0;
         ie_ff <= 1'b0;
         act_ff <= 1'b0;
         irq_ff <= 1'b0;
         rd_req_ff <= 1'b0;
         rd_addr_ff <= adcc_pkg::RST_ADDR;
         start_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         nda_ff <= nxt_nda;
         cda_ff <= nxt_cda;
         en_ff <= nxt_en;
         res_ff <= nxt_res;
         ie_ff <= nxt_ie;
         act_ff <= nxt_act;
         irq_ff <= nxt_irq;
         rd_req_ff <= nxt_rd_req;
         rd_addr_ff <= nxt_rd_addr;
         start_ff <= nxt_start;
      end
   end

   // Sticky status flags
   adcc_flag u_eot (.clk(clk), .sys_rst(sys_rst), .set_i(set_eot), .clr_i(clr_eot), .q_o(eot_q));
   adcc_flag u_eoc (.clk(clk), .sys_rst(sys_rst), .set_i(set_eoc), .clr_i(clr_eoc), .q_o(eoc_q));
   adcc_flag u_err (.clk(clk), .sys_rst(sys_rst), .set_i(set_err), .clr_i(clr_err), .q_o(err_q));

   // Output views
   assign mem_rd.req = rd_req_ff;
   assign mem_rd.addr = rd_addr_ff;
   assign xfer_start = start_ff;
   assign next_desc_addr_reg = nda_ff;
   assign current_desc_addr_reg = cda_ff;
   assign enable_o = en_ff;
   assign resume_o = res_ff;
   // [RULE1] Active bit view
   assign accel_status_reg.active = act_ff;
   assign accel_status_reg.eot = eot_q;
   assign accel_status_reg.eoc = eoc_q;
   assign accel_status_reg.err = err_q;
   assign irq = irq_ff;

   // [RULE1] Active while busy
   AST_ACTIVE_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff != adcc_pkg::ADCC_IDLE) |-> act_ff) // [RULE1]
      else $error("active low while busy");
   // [RULE18] Idle means inactive
   AST_IDLE_INACTIVE: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_IDLE) |-> !act_ff) // [RULE18]
      else $error("active high in idle");
   // [RULE5] Start copies address
   AST_START_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_IDLE && ctl_wr && ctl_enable && !ctl_resume
       && nda_ff != 32'h0000_0000) |=> (cda_ff == $past(nda_ff) && rd_req_ff)) // [RULE5]
      else $error("start did not load current address");
   // [RULE6] No fetch after null
   AST_NULL_STOP: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_DONE && xfer_done && !xfer_err && nda_ff == 32'h0000_0000
       && !res_ff) |=> (state_ff == adcc_pkg::ADCC_IDLE && !rd_req_ff)) // [RULE6]
      else $error("fetch after null next address");
   // [RULE7] Suspend holds transfer
   AST_SUSPEND: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_XFER && !en_ff) |=> !start_ff) // [RULE7]
      else $error("transfer started while disabled");
   // [RULE8] End of transfer and irq
   AST_EOT: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_DONE && xfer_done && !xfer_err && nda_ff != 32'h0000_0000)
      |=> (eot_q && irq == $past(ie_ff) && state_ff == adcc_pkg::ADCC_RD_NXT)) // [RULE8]
      else $error("end of transfer handling wrong");
   // [RULE9] End of chain flag
   AST_EOC: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_DONE && xfer_done && !xfer_err && nda_ff == 32'h0000_0000)
      |=> (eoc_q && irq == $past(ie_ff))) // [RULE9]
      else $error("end of chain handling wrong");
   // [RULE10] Error halts
   AST_ERR_HALT: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == adcc_pkg::ADCC_DONE && xfer_err)
      |=> (err_q && state_ff == adcc_pkg::ADCC_IDLE && $stable(cda_ff))) // [RULE10]
      else $error("error did not halt");
endmodule // adcc_ctrl
`default_nettype wire

// ==== verilog/adcc_pkg.sv ====
// Package with constants and carriers for the descriptor chain controller
`default_nettype none
package adcc_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] NULL_ADDR = 32'h0000_0000;
   // Word offsets inside a descriptor (byte offsets from its base)
   localparam logic [31:0] NXT_FIELD_OFS = 32'h0000_0000;
   localparam logic [31:0] CTL_FIELD_OFS = 32'h0000_001C;
   // Interrupt enable bit in the descriptor control word
   localparam int IE_BIT = 0;
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;

   typedef enum logic [2:0] {
      ADCC_IDLE   = 3'h0,
      ADCC_RD_NXT = 3'h1,
      ADCC_RD_CTL = 3'h3,
      ADCC_XFER   = 3'h2,
      ADCC_DONE   = 3'h6,
      ADCC_RESUME = 3'h7
   } adcc_state_e;

   // Read request towards local memory
   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } adcc_rd_s;

   // Status word visible to software: live active bit plus sticky eot, eoc and err flags
   typedef struct packed {
      logic active;
      logic eot;
      logic eoc;
      logic err;
   } adcc_stat_s;
endpackage : adcc_pkg
`default_nettype wire

// ==== verilog/adcc_flag.sv ====
// Sticky status flag, set dominates clear
`timescale 1ns/10ps
`default_nettype none
module adcc_flag (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic set_i,
   input wire logic clr_i,
   output logic q_o
);
   logic flag_ff;
   logic nxt_flag;

   // Set wins over a clear in the same cycle
   always_comb begin
      nxt_flag = flag_ff;
      if (clr_i) begin
         nxt_flag = 1'b0;
      end
      if (set_i) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign q_o = flag_ff;
endmodule // adcc_flag
`default_nettype wire

// ==== testbench/adcc_partner.sv ====
// Local memory and datapath model facing the chain controller
`timescale 1ns/10ps
`default_nettype none
module adcc_partner (
   input wire logic clk,
   input wire logic sys_rst,
   input wire adcc_pkg::adcc_rd_s mem_rd,
   output logic mem_rvalid,
   output logic [31:0] mem_rdata,
   input wire logic xfer_start,
   output logic xfer_done,
   output logic xfer_err
);
   logic [31:0] mem [logic [31:0]];
   int lat = 1;
   int dly = 4;
   int cnt = 0;
   int dcnt = 0;
   logic fail = 1'h0;
   // One answer per request, in order, after lat cycles
   always @(posedge clk) begin
      mem_rvalid <= 1'h0;
      mem_rdata <= ~mem_rdata;  // Toggles while not valid
      if (sys_rst) begin
         cnt <= 0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_rd.req && !mem_rvalid) begin
         cnt <= cnt + 1;
         if (cnt >= lat - 1) begin
            mem_rvalid <= 1'h1;
            mem_rdata <= mem[mem_rd.addr];
            cnt <= 0;
         end
      end
   end
   // Datapath finishes or fails dly + 1 cycles after the start pulse rises
   always @(posedge clk) begin
      xfer_done <= 1'h0;
      xfer_err <= 1'h0;
      if (sys_rst) begin
         dcnt <= 0;
      end else if (xfer_start) begin
         dcnt <= dly;
      end else if (dcnt == 1) begin
         xfer_done <= !fail;
         xfer_err <= fail;
         dcnt <= 0;
      end else if (dcnt > 1) begin
         dcnt <= dcnt - 1;
      end
   end
endmodule // adcc_partner
`default_nettype wire

// ==== testbench/adcc_ctrl_tb_top.sv ====
// Self-checking bench for the descriptor chain controller
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl_tb_top;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic ctl_wr = 1'h0, ctl_enable = 1'h0, ctl_resume = 1'h0, nda_wr = 1'h0;
   logic clr_eot = 1'h0, clr_eoc = 1'h0, clr_err = 1'h0;
   logic [31:0] nda_wdata = 32'h0000_0000;
   adcc_pkg::adcc_rd_s mem_rd;
   adcc_pkg::adcc_stat_s st;
   logic mem_rvalid, xfer_start, xfer_done, xfer_err, enable_o, resume_o, irq;
   logic [31:0] mem_rdata, nxt, cur, last_rd;
   int failures = 0, checks = 0, n_irq = 0, n_xfer = 0;

   // Core clock, 8 ns period
   always #4 clk = ~clk;

   adcc_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .ctl_wr(ctl_wr),
      .ctl_enable(ctl_enable), .ctl_resume(ctl_resume), .nda_wr(nda_wr),
      .nda_wdata(nda_wdata), .clr_eot(clr_eot), .clr_eoc(clr_eoc),
      .clr_err(clr_err), .mem_rd(mem_rd), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .xfer_start(xfer_start), .xfer_done(xfer_done),
      .xfer_err(xfer_err), .next_desc_addr_reg(nxt), .current_desc_addr_reg(cur),
      .enable_o(enable_o), .resume_o(resume_o), .accel_status_reg(st), .irq(irq));
   adcc_partner i_part (.clk(clk), .sys_rst(sys_rst), .mem_rd(mem_rd),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .xfer_start(xfer_start),
      .xfer_done(xfer_done), .xfer_err(xfer_err));

   // Event counters and last answered read address
   always @(posedge clk) begin
      if (irq === 1'h1) n_irq++;
      if (xfer_start === 1'h1) n_xfer++;
      if (mem_rvalid) last_rd = mem_rd.addr;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_ctl(logic en, logic res);
      @(posedge clk);
      ctl_wr <= 1'h1;
      ctl_enable <= en;
      ctl_resume <= res;
      @(posedge clk);
      ctl_wr <= 1'h0;
   endtask
   task automatic put(logic [31:0] a, logic [31:0] n, logic ie);
      i_part.mem[a] = n;
      i_part.mem[a + adcc_pkg::CTL_FIELD_OFS] = {31'h0000_0000, ie};
   endtask
   task automatic clr();
      @(posedge clk);
      {clr_eot, clr_eoc, clr_err} <= 3'h7;
      @(posedge clk);
      {clr_eot, clr_eoc, clr_err} <= 3'h0;
   endtask
   task automatic go(logic [31:0] a);
      clr();
      nda_wr <= 1'h1;
      nda_wdata <= a;
      @(posedge clk);
      nda_wr <= 1'h0;
      wr_ctl(1'h1, 1'h0);
   endtask
   // Counts a mismatch when a wait runs out
   task automatic limit_hit(int i, int lim);
      if (i >= lim) begin
         failures++;
         $display("unexpected at %0t: wait limit reached", $time);
      end
   endtask
   task automatic wait_idle();
      int i = 0;
      tick(3);
      while (st.active !== 1'h0 && i < 2000) begin
         tick(1);
         i++;
      end
      limit_hit(i, 2000);
      // Let the event counters settle
      @(negedge clk);
   endtask
   // Waits for the first transfer start after x
   task automatic wait_xfer(int x);
      int i = 0;
      while (n_xfer == x && i < 100) begin
         tick(1);
         i++;
      end
      limit_hit(i, 100);
   endtask

   task automatic t_chain();
      int x = n_xfer;
      int q = n_irq;
      put(32'h0000_0100, 32'h0000_0200, 1'h1);
      put(32'h0000_0200, 32'h0000_0000, 1'h0);
      go(32'h0000_0100);
      tick(1);
      check(st.active, 1);
      wait_idle();
      check(st.active, 0);
      check(n_xfer - x, 2);
      check(n_irq - q, 1);
      check({st.eot, st.eoc}, 3);
      check(cur, 32'h0000_0200);
      check(nxt, 32'h0000_0000);
      check(last_rd, 32'h0000_021C);
      $display("test chain done");
   endtask
   task automatic t_err();
      int x = n_xfer;
      int q = n_irq;
      put(32'h0000_0400, 32'h0000_0500, 1'h1);
      i_part.fail = 1'h1;
      go(32'h0000_0400);
      wait_idle();
      i_part.fail = 1'h0;
      check(st.active, 0);
      check({st.err, st.eot}, 2);
      check(cur, 32'h0000_0400);
      check(nxt, 32'h0000_0500);
      check(n_xfer - x + n_irq - q, 1);
      $display("test error done");
   endtask
   task automatic t_resume();
      int x;
      put(32'h0000_0500, 32'h0000_0000, 1'h1);
      clr();
      wr_ctl(1'h1, 1'h1);
      wait_idle();
      check(cur, 32'h0000_0500);
      check(resume_o, 0);
      check(st.eoc, 1);
      x = n_xfer;
      wr_ctl(1'h1, 1'h1);
      tick(8);
      check(last_rd, 32'h0000_0500);
      check({resume_o, st.active}, 0);
      check(n_xfer - x, 0);
      $display("test resume done");
   endtask
   task automatic t_suspend();
      int x = n_xfer;
      i_part.lat = 3;
      put(32'h0000_0600, 32'h0000_0000, 1'h0);
      go(32'h0000_0600);
      wr_ctl(1'h0, 1'h0);
      tick(30);
      check(n_xfer - x, 0);
      check(st.active, 1);
      check(enable_o, 0);
      wr_ctl(1'h1, 1'h0);
      wait_idle();
      i_part.lat = 1;
      check(n_xfer - x, 1);
      check(cur, 32'h0000_0600);
      check(enable_o, 1);
      $display("test suspend done");
   endtask
   task automatic t_append();
      int x = n_xfer;
      i_part.dly = 20;
      put(32'h0000_0700, 32'h0000_0800, 1'h0);
      put(32'h0000_0800, 32'h0000_0000, 1'h0);
      put(32'h0000_0900, 32'h0000_0000, 1'h0);
      go(32'h0000_0700);
      wait_xfer(x);
      put(32'h0000_0800, 32'h0000_0900, 1'h0);
      wr_ctl(1'h1, 1'h1);
      wait_idle();
      check(cur, 32'h0000_0900);
      check(resume_o, 0);
      check(n_xfer - x, 3);
      $display("test append done");
   endtask
   task automatic t_tail();
      int x = n_xfer;
      i_part.dly = 20;
      put(32'h0000_0A00, 32'h0000_0000, 1'h1);
      put(32'h0000_0B00, 32'h0000_0000, 1'h0);
      go(32'h0000_0A00);
      wait_xfer(x);
      put(32'h0000_0A00, 32'h0000_0B00, 1'h1);
      wr_ctl(1'h1, 1'h1);
      wait_idle();
      i_part.dly = 4;
      check(cur, 32'h0000_0B00);
      check(resume_o, 0);
      check(n_xfer - x, 2);
      check(st.eoc, 1);
      $display("test tail append done");
   endtask

   // Main sequence
   initial begin
      tick(6);
      sys_rst <= 1'h0;
      t_chain();
      t_err();
      t_resume();
      t_suspend();
      t_append();
      t_tail();
      final_report();
   end
   // Watchdog well beyond the expected run
   initial begin
      #40000;
      failures++;
      final_report();
   end
endmodule // adcc_ctrl_tb_top
`default_nettype wire
